// >>> rtl/rcr_pkg.sv
// Constants shared by the RC oscillation ratio counter converter
package rcr_pkg;
    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 4;
    // Register addresses, decade counter digits
    localparam logic [7:0] ADDR_DEC0 = 8'h20;
    localparam logic [7:0] ADDR_DEC4 = 8'h24;
    // Register addresses, binary counter nibbles
    localparam logic [7:0] ADDR_BIN0 = 8'h26;
    localparam logic [7:0] ADDR_BIN3 = 8'h29;
    // Register addresses, control
    localparam logic [7:0] ADDR_CTRL0 = 8'h2a;
    localparam logic [7:0] ADDR_MODE = 8'h2b;
    // Control register 0 field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_SEL_BIT = 1;
    // Bits that always read as one
    localparam logic [3:0] CTRL0_RSV = 4'hc;
    localparam logic [3:0] DEC4_RSV = 4'h8;
    localparam logic [3:0] BIN3_RSV = 4'hc;
    // Reset values
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [3:0] DIGIT_RST = 4'h0;
    localparam logic [13:0] BIN_RST = 14'h0000;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    // Reference select encodings
    localparam logic REF_DECADE = 1'b0;
    localparam logic REF_BINARY = 1'b1;
    // Decade counter geometry
    localparam int DEC_DIGITS = 5;
    localparam int DEC_W = 20;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] TOP_DIGIT_MAX = 4'h7;
    localparam logic [3:0] TOP_DIGIT_MASK = 4'h7;
    localparam logic [3:0] DIGIT_ONE = 4'h1;
    localparam logic [19:0] DEC_MAX_VAL = 20'h79999;
    localparam logic [19:0] DEC_ZERO = 20'h00000;
    // Binary counter geometry
    localparam int BIN_W = 14;
    localparam int BIN_NIBS = 4;
    localparam logic [13:0] BIN_MAX = 14'h3fff;
    localparam logic [13:0] BIN_ONE = 14'h0001;
    // Binary counter top nibble holds two bits
    localparam logic [1:0] BIN_TOP_PAD = 2'b00;
endpackage

// >>> rtl/rcr_decade_cnt.sv
// Five digit decimal counter of system clocks, top digit 0 to 7
`timescale 1ns/10ps
module rcr_decade_cnt
    import rcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Software load, one enable per digit
    input wire logic [DEC_DIGITS-1:0] load_en,
    input wire logic [3:0] load_data,
    // Count request
    input wire logic inc,
    // Counter state
    output logic [DEC_W-1:0] value,
    output logic ovf
);
    import rcr_pkg::*;

    // Carry into each digit, carry out of the top is the wrap
    logic [DEC_DIGITS:0] carry;
    assign carry[0] = inc;
    assign ovf = carry[DEC_DIGITS];

    genvar gi;
    generate
        for (gi = 0; gi < DEC_DIGITS; gi++) begin : g_digit
            // Highest digit wraps to zero after seven, others after nine
            localparam logic [3:0] LIM = (gi == DEC_DIGITS - 1) ? TOP_DIGIT_MAX : DIGIT_MAX;
            localparam logic [3:0] MSK = (gi == DEC_DIGITS - 1) ? TOP_DIGIT_MASK : 4'hf;
            logic [3:0] dig_r;
            logic [3:0] dig_nxt;
            wire at_lim = (dig_r == LIM);
            assign carry[gi+1] = carry[gi] & at_lim;
            // Load wins over a count in the same cycle
            assign dig_nxt = load_en[gi] ? (load_data & MSK) :
                             !carry[gi] ? dig_r :
                             at_lim ? DIGIT_RST : 4'(dig_r + DIGIT_ONE);
            // Digit register
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    dig_r <= DIGIT_RST;
                end else begin
                    dig_r <= dig_nxt;
                end
            end
            assign value[gi*4 +: 4] = dig_r;
        end
    endgenerate
endmodule

// >>> rtl/rcr_bin_cnt.sv
// Fourteen stage binary counter of oscillator clocks
`timescale 1ns/10ps
module rcr_bin_cnt
    import rcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Software load, one enable per nibble
    input wire logic [BIN_NIBS-1:0] load_en,
    input wire logic [3:0] load_data,
    // Count request
    input wire logic inc,
    // Counter state
    output logic [BIN_W-1:0] value,
    output logic ovf
);
    import rcr_pkg::*;

    logic [BIN_W-1:0] cnt_r;
    logic [BIN_W-1:0] cnt_nxt;
    logic [BIN_W-1:0] loaded;
    logic [4*BIN_NIBS-1:0] wide;

    // Wrap from all ones to zero
    assign ovf = inc & (cnt_r == BIN_MAX);
    assign value = cnt_r;

    genvar gi;
    generate
        for (gi = 0; gi < BIN_NIBS; gi++) begin : g_nib
            if (gi == BIN_NIBS - 1) begin : g_top
                // Top nibble holds two real bits under the pad
                assign wide[gi*4 +: 4] = load_en[gi] ? load_data :
                    {BIN_TOP_PAD, cnt_r[BIN_W-1 -: 2]};
            end else begin : g_low
                // Replace the addressed nibble with the written data
                assign wide[gi*4 +: 4] = load_en[gi] ? load_data : cnt_r[gi*4 +: 4];
            end
        end
    endgenerate
    assign loaded = wide[BIN_W-1:0];
    // Load wins over a count in the same cycle
    assign cnt_nxt = (|load_en) ? loaded : inc ? 14'(cnt_r + BIN_ONE) : cnt_r;

    // Counter register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= BIN_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// >>> rtl/rcr_conv.sv
// Ratio counter converter: control registers, gating and two counters
`timescale 1ns/10ps
//
// Contract
// - Select 0: decade gates, binary result
// - Select 1: binary gates, decade result
// - Run sync follows run on falling edge
// - Sync rise starts oscillator, binary counts
// - Decade overflow ends run, raises request
// - Sync rise starts decade counting clocks
// - Binary overflow ends run, raises request
// - Decade reads zero after gating overflow
// - Binary result counts oscillator edges in gate
// - Decade result counts clocks in gate
// - Decade to 79999, binary fourteen bits
// - Run clear: oscillator off, no counting
module rcr_conv (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [rcr_pkg::ADDR_W-1:0] addr,
    input wire logic [rcr_pkg::DATA_W-1:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [rcr_pkg::DATA_W-1:0] rdata,
    // Oscillator side
    input wire logic rc_osc_clock,
    output logic rc_osc_enable,
    output logic [3:0] osc_mode_field,
    // Conversion done request
    output logic conversion_irq
);
    import rcr_pkg::*;

    // Control register state
    logic conversion_run_r;        // Conversion in progress
    logic conversion_run_nxt;
    logic reference_select_r;      // Which counter sets the gate
    logic reference_select_nxt;
    logic [3:0] osc_mode_r;        // Oscillation mode
    logic [3:0] osc_mode_nxt;
    // Run sync taken on the falling clock edge
    logic run_sync_enable_r;
    // Oscillator pin synchroniser and edge history
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    // Registered outputs
    logic irq_r;
    logic osc_en_r;
    logic [3:0] rdata_r;
    logic [3:0] rdata_nxt;

    // Counter values and wrap events
    logic [DEC_W-1:0] dec_val;
    logic [BIN_W-1:0] bin_val;
    logic dec_ovf;
    logic bin_ovf;

    // Address decode
    wire hit_ctrl = (addr == ADDR_CTRL0);
    wire hit_mode = (addr == ADDR_MODE);
    wire wr_ctrl = wr_strobe & hit_ctrl;
    wire wr_mode = wr_strobe & hit_mode;

    // Per digit and per nibble write enables
    logic [DEC_DIGITS-1:0] dec_load;
    logic [BIN_NIBS-1:0] bin_load;
    genvar gi;
    generate
        for (gi = 0; gi < DEC_DIGITS; gi++) begin : g_dec_hit
            assign dec_load[gi] = wr_strobe & (addr == 8'(ADDR_DEC0 + gi));
        end
        for (gi = 0; gi < BIN_NIBS; gi++) begin : g_bin_hit
            assign bin_load[gi] = wr_strobe & (addr == 8'(ADDR_BIN0 + gi));
        end
    endgenerate

    // Counting only while run and its falling edge sync are both high
    wire count_en = conversion_run_r & run_sync_enable_r;
    // Rising oscillator edge seen after two synchroniser stages
    wire osc_edge = osc_s2_r & ~osc_s3_r;
    // Decade counts every system clock in the gate, either mode
    wire dec_inc = count_en;
    // Binary counts oscillator edges in the gate, either mode
    wire bin_inc = count_en & osc_edge;
    // The selected counter's wrap closes the gate
    wire sel_ovf = (reference_select_r == REF_BINARY) ? bin_ovf : dec_ovf;

    // Control next state; the gate end beats the run bit of a same cycle write, the select bit still loads
    always_comb begin
        conversion_run_nxt = conversion_run_r;
        reference_select_nxt = reference_select_r;
        if (sel_ovf) begin
            // Hardware ends the conversion
            conversion_run_nxt = 1'b0;
        end else if (wr_ctrl) begin
            // Software start or stop
            conversion_run_nxt = wdata[CTRL_RUN_BIT];
        end
        if (wr_ctrl) begin
            // Select follows every control write
            reference_select_nxt = wdata[CTRL_SEL_BIT];
        end
    end

    // Mode register next state
    assign osc_mode_nxt = wr_mode ? wdata : osc_mode_r;

    // Read multiplexer
    always_comb begin
        rdata_nxt = NIB_ZERO;
        if (!rd_strobe) begin
            // Data only in the cycle after a read
            rdata_nxt = NIB_ZERO;
        end else if (hit_ctrl) begin
            // Run and select with reserved ones
            rdata_nxt = CTRL0_RSV | {2'b00, reference_select_r, conversion_run_r};
        end else if (hit_mode) begin
            // Oscillation mode
            rdata_nxt = osc_mode_r;
        end else if (addr >= ADDR_DEC0 && addr < ADDR_DEC4) begin
            // Lower four decade digits
            rdata_nxt = dec_val[4*(addr - ADDR_DEC0) +: 4];
        end else if (addr == ADDR_DEC4) begin
            // Top decade digit with reserved one
            rdata_nxt = DEC4_RSV | dec_val[DEC_W-1 -: 4];
        end else if (addr >= ADDR_BIN0 && addr < ADDR_BIN3) begin
            // Lower three binary nibbles
            rdata_nxt = bin_val[4*(addr - ADDR_BIN0) +: 4];
        end else if (addr == ADDR_BIN3) begin
            // Top two binary bits with reserved ones
            rdata_nxt = BIN3_RSV | {BIN_TOP_PAD, bin_val[BIN_W-1 -: 2]};
        end else begin
            // Unmapped address reads zero
            rdata_nxt = NIB_ZERO;
        end
    end

    // Control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conversion_run_r <= 1'b0;
            reference_select_r <= REF_DECADE;
            osc_mode_r <= MODE_RST;
        end else begin
            conversion_run_r <= conversion_run_nxt;
            reference_select_r <= reference_select_nxt;
            osc_mode_r <= osc_mode_nxt;
        end
    end

    // Run sync, retimed to the falling system clock edge
    always_ff @(negedge clk or negedge resetn) begin
        if (!resetn) begin
            run_sync_enable_r <= 1'b0;
        end else begin
            run_sync_enable_r <= conversion_run_r;
        end
    end

    // Oscillator pin synchroniser, first stage read only by the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else begin
            osc_s1_r <= rc_osc_clock;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // Outputs: request pulse, oscillator enable, read data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_r <= 1'b0;
            osc_en_r <= 1'b0;
            rdata_r <= NIB_ZERO;
        end else begin
            irq_r <= sel_ovf;
            osc_en_r <= count_en;
            rdata_r <= rdata_nxt;
        end
    end

    assign conversion_irq = irq_r;
    assign rc_osc_enable = osc_en_r;
    assign osc_mode_field = osc_mode_r;
    assign rdata = rdata_r;

    // Decimal gate or result counter
    rcr_decade_cnt u_dec (
        .clk(clk),
        .resetn(resetn),
        .load_en(dec_load),
        .load_data(wdata),
        .inc(dec_inc),
        .value(dec_val),
        .ovf(dec_ovf)
    );

    // Binary gate or result counter
    rcr_bin_cnt u_bin (
        .clk(clk),
        .resetn(resetn),
        .load_en(bin_load),
        .load_data(wdata),
        .inc(bin_inc),
        .value(bin_val),
        .ovf(bin_ovf)
    );

    // Gate end: overflow, then run low and request high together
    sequence s_gate_end;
        sel_ovf ##1 (!conversion_run_r && irq_r);
    endsequence

    // Idle: no run and no software write
    sequence s_idle;
        !count_en && !wr_strobe;
    endsequence

    // Selected overflow ends the run and raises the request
    property p_ovf_ends;
        @(posedge clk) disable iff (!resetn)
        sel_ovf |-> s_gate_end;
    endproperty
    a_ovf_ends: assert property (p_ovf_ends) else $error("overflow did not end run");

    // Request only ever follows a selected overflow
    property p_irq_cause;
        @(posedge clk) disable iff (!resetn)
        irq_r |-> $past(sel_ovf);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without overflow");

    // Run sync is high at the first rising edge after run rises
    property p_sync_follows;
        @(posedge clk) disable iff (!resetn)
        $rose(conversion_run_r) |-> run_sync_enable_r;
    endproperty
    a_sync_follows: assert property (p_sync_follows) else $error("run sync late");

    // Oscillator enable follows the gate one cycle later
    property p_osc_start;
        @(posedge clk) disable iff (!resetn)
        $rose(count_en) |=> rc_osc_enable ##1 (rc_osc_enable || !conversion_run_r);
    endproperty
    a_osc_start: assert property (p_osc_start) else $error("oscillator not started");

    // No counting and no oscillation while idle
    property p_idle_frozen;
        @(posedge clk) disable iff (!resetn)
        s_idle |=> ($stable(dec_val) && $stable(bin_val) && !rc_osc_enable);
    endproperty
    a_idle_frozen: assert property (p_idle_frozen) else $error("count while halted");

    // Decade at its top wraps to all zeros
    property p_dec_wrap;
        @(posedge clk) disable iff (!resetn)
        (count_en && !wr_strobe && dec_val == DEC_MAX_VAL) |=> (dec_val == DEC_ZERO);
    endproperty
    a_dec_wrap: assert property (p_dec_wrap) else $error("decade did not wrap to zero");

    // Binary steps by one on each gated oscillator edge
    property p_bin_step;
        @(posedge clk) disable iff (!resetn)
        (bin_inc && !wr_strobe && bin_val != BIN_MAX) |=> (bin_val == $past(bin_val) + BIN_ONE);
    endproperty
    a_bin_step: assert property (p_bin_step) else $error("binary missed an edge");

    // Binary holds when no gated oscillator edge arrives
    property p_bin_hold;
        @(posedge clk) disable iff (!resetn)
        (!bin_inc && !wr_strobe) |=> $stable(bin_val);
    endproperty
    a_bin_hold: assert property (p_bin_hold) else $error("binary counted without edge");

    // Binary wrap flagged only from all ones
    property p_bin_wrap;
        @(posedge clk) disable iff (!resetn)
        bin_ovf |-> (bin_val == BIN_MAX) ##1 ($past(wr_strobe) || bin_val == BIN_RST);
    endproperty
    a_bin_wrap: assert property (p_bin_wrap) else $error("binary wrap wrong");

    // In binary gating the decade keeps counting until the gate ends
    property p_dec_runs;
        @(posedge clk) disable iff (!resetn)
        (count_en && reference_select_r == REF_BINARY && !wr_strobe && !dec_ovf)
            |=> !$stable(dec_val);
    endproperty
    a_dec_runs: assert property (p_dec_runs) else $error("decade stalled in gate");

    // Read data stand only in the cycle after a read
    property p_rd_idle;
        @(posedge clk) disable iff (!resetn)
        !rd_strobe |=> (rdata == NIB_ZERO);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

    // Request lasts a single cycle
    property p_irq_single;
        @(posedge clk) disable iff (!resetn)
        irq_r |=> !irq_r;
    endproperty
    a_irq_single: assert property (p_irq_single) else $error("request longer than one cycle");

    // Oscillator enable drops one cycle after run falls
    property p_osc_stop;
        @(posedge clk) disable iff (!resetn)
        $fell(conversion_run_r) |-> ##1 !rc_osc_enable;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator left running");

    // In decade gating the decade steps on every gated clock
    property p_dec_gates;
        @(posedge clk) disable iff (!resetn)
        (count_en && reference_select_r == REF_DECADE && !wr_strobe) |=> !$stable(dec_val);
    endproperty
    a_dec_gates: assert property (p_dec_gates) else $error("decade gate stalled");

    // Run sync stays low while run stays low
    property p_sync_idle;
        @(posedge clk) disable iff (!resetn)
        (!conversion_run_r && !wr_ctrl) |=> !run_sync_enable_r;
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("run sync without run");

    // Select changes only on a control write
    property p_sel_hold;
        @(posedge clk) disable iff (!resetn)
        !wr_ctrl |=> $stable(reference_select_r);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select changed without write");

endmodule

// >>> tb/rcr_osc_model.sv
// Behavioural RC oscillator seen from the converter pins
`timescale 1ns/10ps
module rcr_osc_model #(
    parameter realtime HALF = 20.0,
    parameter realtime LAG = 1.3
) (
    // Run request from the converter
    input wire logic enable,
    // Oscillator clock back to the converter
    output logic osc
);
    // Oscillates only while enabled, idles low otherwise
    initial begin
        osc = 1'b0;
        forever begin
            @(posedge enable);
            // Offset keeps edges away from system clock edges
            #(HALF + LAG);
            while (enable === 1'b1) begin
                osc = 1'b1;
                #(HALF);
                osc = 1'b0;
                #(HALF);
            end
        end
    end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the ratio counter converter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    import rcr_pkg::*;
    // Design ports
    logic clk, resetn, wr_strobe, rd_strobe;
    logic [7:0] addr;
    logic [3:0] wdata;
    logic [3:0] rdata;
    logic rc_osc_clock, rc_osc_enable, conversion_irq;
    logic [3:0] osc_mode_field;
    // Bookkeeping
    int failures, cmp_count;
    logic [31:0] k1, k20, b200, b400, d2, d5, v, w;
    logic [3:0] r;
    logic seen;

    rcr_conv DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .rc_osc_clock(rc_osc_clock), .rc_osc_enable(rc_osc_enable),
        .osc_mode_field(osc_mode_field), .conversion_irq(conversion_irq));

    // Oscillator period is exactly ten system clocks
    rcr_osc_model #(.HALF(20.0), .LAG(1.3)) osc_i (.enable(rc_osc_enable), .osc(rc_osc_clock));

    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // One cycle register write
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask

    // One cycle register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [3:0] d);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1 d = rdata;
    endtask

    // Decimal preset across five digits
    task automatic set_dec(input int val);
        for (int i = 0; i < 5; i++) wr(ADDR_DEC0 + 8'(i), 4'((val / (10 ** i)) % 10));
    endtask

    // Binary preset across four nibbles
    task automatic set_bin(input int val);
        for (int i = 0; i < 4; i++) wr(ADDR_BIN0 + 8'(i), 4'((val >> (4 * i)) & 15));
    endtask

    // Decade counter as an integer
    task automatic get_dec(output logic [31:0] val);
        logic [3:0] d;
        val = 0;
        for (int i = 0; i < 5; i++) begin
            rd(ADDR_DEC0 + 8'(i), d);
            if (i == 4) d = {1'b0, d[2:0]};
            val = val + d * (10 ** i);
        end
    endtask

    // Binary counter as an integer
    task automatic get_bin(output logic [31:0] val);
        logic [3:0] d;
        val = 0;
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_BIN0 + 8'(i), d);
            if (i == 3) d = {2'b00, d[1:0]};
            val = val | (32'(d) << (4 * i));
        end
    endtask

    // Edges from the start write until the request, bounded
    task automatic wait_irq(output logic [31:0] k);
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (conversion_irq !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            failures++;
            $display("wrong value irq_wait expected 1 seen 0");
            wrap_up();
        end
        @(posedge clk);
        #1 `CHK("irq_pulse", 1'b0, conversion_irq)
    endtask

    // Decade gated run of g clocks
    task automatic dec_run(input int g, output logic [31:0] lat, output logic [31:0] res);
        set_bin(0);
        set_dec(80000 - g);
        wr(ADDR_MODE, 4'h1);
        wr(ADDR_CTRL0, 4'h1);
        wait_irq(lat);
        `CHK("dec_latency_window", 1'b1, (lat >= g && lat <= g + 2))
        rd(ADDR_CTRL0, r);
        `CHK("ctrl0_after_dec", 4'hc, r)
        get_dec(v);
        `CHK("dec_after_gate", 32'h0, v)
        get_bin(res);
        repeat (40) @(posedge clk);
        get_bin(v);
        `CHK("bin_frozen", res, v)
        `CHK("osc_off", 1'b0, rc_osc_enable)
    endtask

    // Binary gated run of n oscillator periods
    task automatic bin_run(input int n, output logic [31:0] res);
        set_dec(0);
        set_bin(16384 - n);
        wr(ADDR_MODE, 4'h2);
        wr(ADDR_CTRL0, 4'h3);
        wait_irq(v);
        rd(ADDR_CTRL0, r);
        `CHK("ctrl0_after_bin", 4'he, r)
        get_bin(v);
        `CHK("bin_after_gate", 32'h0, v)
        get_dec(res);
        repeat (40) @(posedge clk);
        get_dec(v);
        `CHK("dec_frozen", res, v)
    endtask

    // Hang guard
    initial begin
        #400000;
        failures++;
        $display("wrong value run_time expected done seen timeout");
        wrap_up();
    end

    // Main sequence
    initial begin
        failures = 0;
        cmp_count = 0;
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 4'h0;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        // Reset values and unmapped places
        for (int a = 8'h1f; a <= 8'h2c; a++) begin
            rd(8'(a), r);
            `CHK("reset_read", (a == 8'h24) ? 4'h8 : (a == 8'h29 || a == 8'h2a) ? 4'hc : 4'h0, r)
        end
        `CHK("osc_idle", 1'b0, rc_osc_enable)
        // Top digit three bits, top nibble two bits
        wr(ADDR_DEC4, 4'hf);
        rd(ADDR_DEC4, r);
        `CHK("dec4_top", 4'hf, r)
        wr(ADDR_BIN3, 4'hf);
        rd(ADDR_BIN3, r);
        `CHK("bin3_top", 4'hf, r)
        // Every mode code reaches the oscillator
        for (int m = 0; m < 16; m++) begin
            wr(ADDR_MODE, 4'(m));
            rd(ADDR_MODE, r);
            `CHK("mode_read", 4'(m), r)
            `CHK("mode_pin", 4'(m), osc_mode_field)
        end
        // Idle counters hold their values
        set_dec(5);
        set_bin(7);
        repeat (30) @(posedge clk);
        get_dec(v);
        `CHK("dec_idle", 32'd5, v)
        get_bin(v);
        `CHK("bin_idle", 32'd7, v)
        // Decade gating: exact gate length
        dec_run(1, k1, v);
        dec_run(20, k20, v);
        `CHK("gate_len_diff", 32'd19, k20 - k1)
        dec_run(200, k1, b200);
        dec_run(400, k1, b400);
        `CHK("bin_result_window", 1'b1, (b200 >= 17 && b200 <= 21))
        `CHK("bin_result_diff", 32'd20, b400 - b200)
        // Binary gating from n below the wrap to zero
        bin_run(1, v);
        bin_run(2, d2);
        bin_run(5, d5);
        `CHK("dec_result_window", 1'b1, (d2 >= 12 && d2 <= 28))
        `CHK("dec_result_diff", 32'd30, d5 - d2)
        // Abort in mid run gives no request
        set_dec(0);
        set_bin(0);
        wr(ADDR_CTRL0, 4'h1);
        repeat (30) @(posedge clk);
        `CHK("osc_running", 1'b1, rc_osc_enable)
        wr(ADDR_CTRL0, 4'h0);
        seen = 1'b0;
        repeat (40) begin
            @(posedge clk);
            #1 if (conversion_irq === 1'b1) seen = 1'b1;
        end
        `CHK("abort_no_irq", 1'b0, seen)
        `CHK("abort_osc_off", 1'b0, rc_osc_enable)
        get_dec(v);
        repeat (20) @(posedge clk);
        get_dec(w);
        `CHK("abort_dec_frozen", v, w)
        wrap_up();
    end
endmodule
